// ### include/sleep_params.svh
`ifndef SLEEP_PARAMS_SVH
`define SLEEP_PARAMS_SVH
`define SPM_OFF_SLEEP_CTRL   8'h00
`define SPM_OFF_CORE_CTRL    8'h04
`define SPM_OFF_CLK_GATE     8'h08
`define SPM_OFF_AIN_DIS0     8'h0c
`define SPM_OFF_AIN_DIS1     8'h10
`define SPM_OFF_ANALOG_CTRL  8'h14
`define SPM_OFF_STATUS       8'h18
`define SPM_SE_BIT           0
`define SPM_SM_LSB           1
`define SPM_SM_MSB           3
`define SPM_DBG_DIS_BIT      7
`define SPM_AN_ADC_EN_BIT    0
`define SPM_AN_CMP_EN_BIT    1
`define SPM_AN_CMP_REF_BIT   2
`define SPM_AN_WDT_EN_BIT    3
`define SPM_RST_BYTE         8'h00
`define SPM_XSTBY_WAKE_CYC   4'd6
`define SPM_INT_HOLD_CYC     4'd4
`define SPM_SLVERR           2'b10
`define SPM_OKAY             2'b00
`endif

// ### include/sleep_pkg.sv
package sleep_pkg;
    typedef enum logic [2:0] {
        MODE_IDLE, MODE_NOISE, MODE_PDOWN, MODE_PSAVE,
        MODE_RSVD, MODE_STBY, MODE_XSTBY
    } sleep_mode_e;
    typedef enum logic [2:0] {
        ST_RUN, ST_SLEEP, ST_WAKE, ST_HOLD
    } sleep_state_e;
endpackage : sleep_pkg

// ### hdl/mode_decode.sv
`timescale 1ns/1ps
module mode_decode (
    input  wire logic [2:0]         sel,
    input  wire logic               xtal_clk,
    output sleep_pkg::sleep_mode_e  mode
);
    always_comb begin
        case (sel)
            3'h0:    mode = sleep_pkg::MODE_IDLE;
            3'h1:    mode = sleep_pkg::MODE_NOISE;
            3'h2:    mode = sleep_pkg::MODE_PDOWN;
            3'h3:    mode = sleep_pkg::MODE_PSAVE;
            // standby codes need a crystal clock, else power-down (code 6) or power-save (code 7)
            3'h6:    mode = xtal_clk ? sleep_pkg::MODE_STBY
                                     : sleep_pkg::MODE_PDOWN;
            3'h7:    mode = xtal_clk ? sleep_pkg::MODE_XSTBY
                                     : sleep_pkg::MODE_PSAVE;
            default: mode = sleep_pkg::MODE_RSVD;
        endcase
    end
endmodule : mode_decode

// ### hdl/gate_bank.sv
`timescale 1ns/1ps
module gate_bank #(
    parameter int N = 8
) (
    input  wire logic [N-1:0] gate_bits,
    input  wire logic         periph_run,
    output logic      [N-1:0] clk_en,
    output logic      [N-1:0] io_block
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            assign clk_en[i]   = periph_run & ~gate_bits[i];
            assign io_block[i] = gate_bits[i];
        end
    endgenerate
endmodule : gate_bank

// ### hdl/sleep_power_manager.sv
`timescale 1ns/1ps
`include "sleep_params.svh"
module sleep_power_manager #(
    parameter int NPER = 8,
    parameter int NPIN = 8
) (
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            clk_en,
    input  wire logic [31:0]     s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [31:0]     s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire logic            sleep_instr,
    input  wire logic            wake_event,
    input  wire logic            startup_done,
    input  wire logic            xtal_clk,
    input  wire logic            onchip_debug_fuse,
    input  wire logic            test_port_fuse,
    input  wire logic [2:0]      brownout_level_fuse,
    input  wire logic            timer2_async,
    input  wire logic [NPIN-1:0] wake_pin_mask,
    output logic                 core_halt,
    output logic                 cpu_clk_on,
    output logic                 io_clk_on,
    output logic                 adc_clk_on,
    output logic                 async_clk_on,
    output logic                 main_osc_on,
    output logic                 timer2_run,
    output logic [NPER-1:0]      periph_clk_en,
    output logic [NPER-1:0]      periph_io_block,
    output logic                 adc_enable,
    output logic                 adc_extended,
    output logic                 cmp_enable,
    output logic                 vref_enable,
    output logic                 bod_enable,
    output logic                 wdt_enable,
    output logic                 debug_enable,
    output logic [NPIN-1:0]      in_buf_en_0,
    output logic [NPIN-1:0]      in_buf_en_1
);
    logic [7:0]      sleep_control_reg_r;
    logic [7:0]      core_control_reg_r;
    logic [NPER-1:0] clock_gating_reg_r;
    logic [NPIN-1:0] analog_pin_input_disable_0_r;
    logic [NPIN-1:0] analog_pin_input_disable_1_r;
    logic [7:0]      analog_ctrl_r;
    logic            adc_was_off_r;
    logic [3:0]      cnt_r;
    logic [2:0]      mode_lat_r;
    sleep_pkg::sleep_state_e st_r;
    sleep_pkg::sleep_mode_e  mode_now;
    sleep_pkg::sleep_mode_e  mode_act;
    logic            asleep;
    logic            periph_run;
    logic [NPER-1:0] gate_en;
    logic [NPER-1:0] gate_blk;
    logic            aw_hold_r;
    logic            w_hold_r;
    logic [7:0]      aw_addr_r;
    logic [31:0]     w_data_r;
    logic [3:0]      w_strb_r;
    logic            do_write;
    logic            aw_ok;
    logic [31:0]     rd_val;
    logic            rd_ok;
    logic            clks_off;

    mode_decode u_dec (
        .sel      (sleep_control_reg_r[`SPM_SM_MSB:`SPM_SM_LSB]),
        .xtal_clk (xtal_clk),
        .mode     (mode_now)
    );

    assign mode_act = sleep_pkg::sleep_mode_e'(mode_lat_r);
    assign asleep   = (st_r == sleep_pkg::ST_SLEEP);
    // gating effective in active and idle
    assign periph_run = !asleep || mode_act == sleep_pkg::MODE_IDLE;

    gate_bank #(.N(NPER)) u_gate (
        .gate_bits  (clock_gating_reg_r),
        .periph_run (periph_run),
        .clk_en     (gate_en),
        .io_block   (gate_blk)
    );

    // sleep sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r       <= sleep_pkg::ST_RUN;
            cnt_r      <= 4'h0;
            mode_lat_r <= 3'h0;
        end else if (clk_en) begin
            case (st_r)
                sleep_pkg::ST_RUN: begin
                    if (sleep_instr && sleep_control_reg_r[`SPM_SE_BIT] &&
                        mode_now != sleep_pkg::MODE_RSVD) begin
                        st_r       <= sleep_pkg::ST_SLEEP;
                        mode_lat_r <= mode_now;
                    end
                end
                sleep_pkg::ST_SLEEP: begin
                    if (wake_event) begin
                        st_r <= sleep_pkg::ST_WAKE;
                        if (mode_act == sleep_pkg::MODE_XSTBY ||
                            mode_act == sleep_pkg::MODE_STBY)
                            cnt_r <= `SPM_XSTBY_WAKE_CYC - 4'd1;
                        else
                            cnt_r <= 4'h0;
                    end
                end
                sleep_pkg::ST_WAKE: begin
                    if (cnt_r != 4'h0)
                        cnt_r <= cnt_r - 4'd1;
                    else if (startup_done || mode_act ==
                             sleep_pkg::MODE_XSTBY || mode_act ==
                             sleep_pkg::MODE_STBY) begin
                        st_r  <= sleep_pkg::ST_HOLD;
                        cnt_r <= `SPM_INT_HOLD_CYC - 4'd1;
                    end
                end
                sleep_pkg::ST_HOLD: begin
                    if (cnt_r != 4'h0)
                        cnt_r <= cnt_r - 4'd1;
                    else
                        st_r <= sleep_pkg::ST_RUN;
                end
                default: st_r <= sleep_pkg::ST_RUN;
            endcase
        end
    end

    // io and converter clocks both stopped
    assign clks_off = asleep && mode_act != sleep_pkg::MODE_IDLE &&
                      mode_act != sleep_pkg::MODE_NOISE;

    // clock outputs, registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            core_halt    <= 1'b0;
            cpu_clk_on   <= 1'b1;
            io_clk_on    <= 1'b1;
            adc_clk_on   <= 1'b1;
            async_clk_on <= 1'b1;
            main_osc_on  <= 1'b1;
            timer2_run   <= 1'b1;
        end else if (clk_en) begin
            core_halt  <= st_r != sleep_pkg::ST_RUN;
            cpu_clk_on <= !asleep;
            io_clk_on  <= !asleep || mode_act == sleep_pkg::MODE_IDLE;
            adc_clk_on <= !asleep || mode_act == sleep_pkg::MODE_IDLE ||
                          mode_act == sleep_pkg::MODE_NOISE;
            async_clk_on <= !asleep || mode_act != sleep_pkg::MODE_PDOWN;
            main_osc_on <= !asleep || onchip_debug_fuse ||
                           mode_act == sleep_pkg::MODE_IDLE ||
                           mode_act == sleep_pkg::MODE_NOISE ||
                           mode_act == sleep_pkg::MODE_STBY ||
                           mode_act == sleep_pkg::MODE_XSTBY;
            timer2_run <= !asleep || mode_act == sleep_pkg::MODE_IDLE ||
                          mode_act == sleep_pkg::MODE_NOISE ||
                          ((mode_act == sleep_pkg::MODE_PSAVE ||
                            mode_act == sleep_pkg::MODE_XSTBY) &&
                           timer2_async);
        end
    end

    // peripheral gates and analog enables, registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            periph_clk_en   <= '0;
            periph_io_block <= '0;
            adc_enable      <= 1'b0;
            cmp_enable      <= 1'b0;
            vref_enable     <= 1'b0;
            bod_enable      <= 1'b0;
            wdt_enable      <= 1'b0;
            debug_enable    <= 1'b0;
            in_buf_en_0     <= '1;
            in_buf_en_1     <= '1;
        end else if (clk_en) begin
            periph_clk_en   <= gate_en;
            periph_io_block <= gate_blk;
            adc_enable <= analog_ctrl_r[`SPM_AN_ADC_EN_BIT];
            cmp_enable <= analog_ctrl_r[`SPM_AN_CMP_EN_BIT] &&
                          (!asleep || !clks_off);
            vref_enable <= (brownout_level_fuse != 3'h7) ||
                           analog_ctrl_r[`SPM_AN_ADC_EN_BIT] ||
                           (analog_ctrl_r[`SPM_AN_CMP_EN_BIT] &&
                            analog_ctrl_r[`SPM_AN_CMP_REF_BIT]);
            bod_enable <= brownout_level_fuse != 3'h7;
            wdt_enable <= analog_ctrl_r[`SPM_AN_WDT_EN_BIT];
            debug_enable <= onchip_debug_fuse && test_port_fuse &&
                            !core_control_reg_r[`SPM_DBG_DIS_BIT];
            // deep sleep kills buffers except wake pins
            in_buf_en_0 <= ~analog_pin_input_disable_0_r &
                           (clks_off ? wake_pin_mask : '1);
            in_buf_en_1 <= ~analog_pin_input_disable_1_r &
                           (clks_off ? wake_pin_mask : '1);
        end
    end

    // extended conversion after off then on
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adc_was_off_r <= 1'b1;
            adc_extended  <= 1'b0;
        end else if (clk_en) begin
            if (!analog_ctrl_r[`SPM_AN_ADC_EN_BIT])
                adc_was_off_r <= 1'b1;
            else
                adc_was_off_r <= 1'b0;
            if (analog_ctrl_r[`SPM_AN_ADC_EN_BIT] && adc_was_off_r)
                adc_extended <= 1'b1;
            else if (!analog_ctrl_r[`SPM_AN_ADC_EN_BIT])
                adc_extended <= 1'b0;
        end
    end

    // axi write channel
    assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign aw_ok = aw_addr_r == `SPM_OFF_SLEEP_CTRL ||
                   aw_addr_r == `SPM_OFF_CORE_CTRL ||
                   aw_addr_r == `SPM_OFF_CLK_GATE ||
                   aw_addr_r == `SPM_OFF_AIN_DIS0 ||
                   aw_addr_r == `SPM_OFF_AIN_DIS1 ||
                   aw_addr_r == `SPM_OFF_ANALOG_CTRL;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0;
            w_strb_r      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SPM_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awready && s_axi_awvalid) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_ok ? `SPM_OKAY : `SPM_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register file, byte lane 0 only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleep_control_reg_r          <= `SPM_RST_BYTE;
            core_control_reg_r           <= `SPM_RST_BYTE;
            clock_gating_reg_r           <= '0;
            analog_pin_input_disable_0_r <= '0;
            analog_pin_input_disable_1_r <= '0;
            analog_ctrl_r                <= `SPM_RST_BYTE;
        end else if (clk_en && do_write && w_strb_r[0]) begin
            if (aw_addr_r == `SPM_OFF_SLEEP_CTRL)
                sleep_control_reg_r <= {4'h0, w_data_r[3:0]};
            else if (aw_addr_r == `SPM_OFF_CORE_CTRL)
                core_control_reg_r <= {w_data_r[7], 7'h00};
            else if (aw_addr_r == `SPM_OFF_CLK_GATE)
                clock_gating_reg_r <= w_data_r[NPER-1:0];
            else if (aw_addr_r == `SPM_OFF_AIN_DIS0)
                analog_pin_input_disable_0_r <= w_data_r[NPIN-1:0];
            else if (aw_addr_r == `SPM_OFF_AIN_DIS1)
                analog_pin_input_disable_1_r <= w_data_r[NPIN-1:0];
            else if (aw_addr_r == `SPM_OFF_ANALOG_CTRL)
                analog_ctrl_r <= {4'h0, w_data_r[3:0]};
        end
    end

    // read decode
    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        if (s_axi_araddr[7:2] == 6'(`SPM_OFF_SLEEP_CTRL >> 2))
            rd_val = {24'h0, sleep_control_reg_r};
        else if (s_axi_araddr[7:2] == 6'(`SPM_OFF_CORE_CTRL >> 2))
            rd_val = {24'h0, core_control_reg_r};
        else if (s_axi_araddr[7:2] == 6'(`SPM_OFF_CLK_GATE >> 2))
            rd_val[NPER-1:0] = clock_gating_reg_r;
        else if (s_axi_araddr[7:2] == 6'(`SPM_OFF_AIN_DIS0 >> 2))
            rd_val[NPIN-1:0] = analog_pin_input_disable_0_r;
        else if (s_axi_araddr[7:2] == 6'(`SPM_OFF_AIN_DIS1 >> 2))
            rd_val[NPIN-1:0] = analog_pin_input_disable_1_r;
        else if (s_axi_araddr[7:2] == 6'(`SPM_OFF_ANALOG_CTRL >> 2))
            rd_val = {24'h0, analog_ctrl_r};
        else if (s_axi_araddr[7:2] == 6'(`SPM_OFF_STATUS >> 2))
            rd_val = {24'h0, adc_extended, debug_enable, vref_enable,
                      1'b0, 1'b0, mode_lat_r & {3{asleep}}};
        else
            rd_ok = 1'b0;
        if (s_axi_araddr[31:8] != 24'h0)
            rd_ok = 1'b0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `SPM_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                             s_axi_arvalid;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_ok ? rd_val : 32'h0;
                s_axi_rresp  <= rd_ok ? `SPM_OKAY : `SPM_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : sleep_power_manager

// ### bench/spm_checker.sv
`timescale 1ns/1ps
module spm_checker #(
    parameter int NPIN = 8
) (
    input wire logic            clock,
    input wire logic            rst,
    input wire logic            sleep_instr,
    input wire logic            core_halt,
    input wire logic            cpu_clk_on,
    input wire logic            io_clk_on,
    input wire logic            adc_clk_on,
    input wire logic            main_osc_on,
    input wire logic            vref_enable,
    input wire logic            bod_enable,
    input wire logic            debug_enable,
    input wire logic            onchip_debug_fuse,
    input wire logic            test_port_fuse,
    input wire logic [2:0]      brownout_level_fuse,
    input wire logic [NPIN-1:0] wake_pin_mask,
    input wire logic [NPIN-1:0] in_buf_en_0,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_bod; (brownout_level_fuse != 3'h7) [*3] |-> bod_enable;
    endproperty
    a_bod: assert property (p_bod) else $error("bod off with fuse set");
    property p_vref; bod_enable [*2] |-> vref_enable;
    endproperty
    a_vref: assert property (p_vref) else $error("vref off for bod");
    property p_dbg; (!onchip_debug_fuse || !test_port_fuse) [*3] |-> !debug_enable;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug on, fuse clear");
    property p_osc; onchip_debug_fuse [*3] |-> main_osc_on;
    endproperty
    a_osc: assert property (p_osc) else $error("osc off with debug");
    property p_run; !core_halt [*2] |-> cpu_clk_on && io_clk_on;
    endproperty
    a_run: assert property (p_run) else $error("clock off while running");
    property p_sleep; $rose(core_halt) |-> $past(sleep_instr, 2) || $past(sleep_instr, 3);
    endproperty
    a_sleep: assert property (p_sleep) else $error("halt without sleep");
    property p_hold; $fell(core_halt) |-> $past(core_halt, 5);
    endproperty
    a_hold: assert property (p_hold) else $error("wake hold too short");
    property p_buf; (!io_clk_on && !adc_clk_on) [*2] |-> (in_buf_en_0 & ~wake_pin_mask) == '0;
    endproperty
    a_buf: assert property (p_buf) else $error("input buffer left on");
    c_sleep: cover property ($rose(core_halt));
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule : spm_checker

// ### bench/core_model.sv
`timescale 1ns/1ps
module core_model (
    input  wire logic clock,
    input  wire logic core_halt,
    output logic      sleep_instr,
    output logic      wake_event,
    output logic      startup_done
);
    initial {sleep_instr, wake_event, startup_done} = 3'b000;
    task automatic exec_sleep();
        sleep_instr <= 1'b1;
        @(posedge clock);
        sleep_instr <= 1'b0;
    endtask : exec_sleep
    // wake request; oscillator reports stable settle cycles later
    task automatic wake(input int settle);
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        repeat (settle) @(posedge clock);
        if (core_halt) startup_done <= 1'b1;
    endtask : wake
    always @(posedge clock) if (!core_halt) startup_done <= 1'b0;
endmodule : core_model

// ### bench/tb_sleep_power_manager.sv
`timescale 1ns/1ps
`define CHK(a, b) check_val(32'(a), 32'(b))
module tb_sleep_power_manager;
    logic        clock = 1'b0, rst = 1'b1, clk_en = 1'b1, xtal_clk = 1'b1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timer2_async = 1'b0;
    logic        onchip_debug_fuse = 1'b0, test_port_fuse = 1'b0;
    logic [2:0]  brownout_level_fuse = 3'h7;
    logic [7:0]  wake_pin_mask = 8'h05;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, sleep_instr, wake_event, startup_done, core_halt;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        cpu_clk_on, io_clk_on, adc_clk_on, async_clk_on, main_osc_on;
    logic        timer2_run, adc_enable, adc_extended, cmp_enable, vref_enable;
    logic        bod_enable, wdt_enable, debug_enable;
    logic [7:0]  periph_clk_en, periph_io_block, in_buf_en_0, in_buf_en_1;
    int          n_errors = 0, samples_checked = 0;
    logic [2:0]  code [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h7};
    logic [2:0]  idx [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h3};
    logic [6:0]  xt = 7'h3f, io = 7'h01, ac = 7'h03, osc = 7'h33;
    always #2.5 clock = ~clock;
    sleep_power_manager uut (.*);
    core_model core (.clock(clock), .core_halt(core_halt),
        .sleep_instr(sleep_instr), .wake_event(wake_event),
        .startup_done(startup_done));
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic hang();
        n_errors++;
        end_sim();
    endtask : hang
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 64) hang();
        `CHK(s_axi_bresp, er);
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        s_axi_araddr <= {24'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 64) hang();
        `CHK(s_axi_rdata, ed);
        `CHK(s_axi_rresp, er);
        @(posedge clock);
    endtask : rd
    task automatic wait_run(output int c);
        for (c = 0; c < 100 && core_halt !== 1'b0; c++) @(posedge clock);
        if (c == 100) hang();
    endtask : wait_run
    task automatic sleep_now();
        core.exec_sleep();
        repeat (4) @(posedge clock);
    endtask : sleep_now
    initial begin
        int i, c;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd(8'h00, 32'h0, 2'b00);
        rd(8'h1c, 32'h0, 2'b10);
        wr(8'h1c, 32'h1, 2'b10);
        wr(8'h00, 32'h4, 2'b00);
        sleep_now();
        `CHK(core_halt, 1'b0);
        wr(8'h00, 32'h9, 2'b00);
        sleep_now();
        `CHK(core_halt, 1'b0);
        wr(8'h14, 32'h0f, 2'b00);
        for (i = 0; i < 7; i++) begin
            xtal_clk <= xt[i];
            // odd passes run timer2 from its own clock
            timer2_async <= i[0];
            wr(8'h00, {28'h0, code[i], 1'b1}, 2'b00);
            sleep_now();
            rd(8'h18, {24'h0, 5'h14, idx[i]}, 2'b00);
            `CHK(cpu_clk_on, 1'b0);
            `CHK({io_clk_on, adc_clk_on}, {io[i], ac[i]});
            `CHK(main_osc_on, osc[i]);
            `CHK(async_clk_on, i != 2);
            `CHK(timer2_run, ac[i] | i[0]);
            `CHK(cmp_enable, ac[i]);
            `CHK({adc_enable, wdt_enable, vref_enable}, 3'h7);
            `CHK(in_buf_en_0, ac[i] ? 8'hff : 8'h05);
            fork
                core.wake(20);
                wait_run(c);
            join
            if (code[i][2] && xt[i])
                `CHK(c >= 9 && c <= 13, 1'b1);
            else
                `CHK(c >= 24, 1'b1);
            wr(8'h00, 32'h0, 2'b00);
        end
        wr(8'h08, 32'ha5, 2'b00);
        `CHK({periph_clk_en, periph_io_block}, 16'h5aa5);
        rd(8'h08, 32'ha5, 2'b00);
        wr(8'h08, 32'h0, 2'b00);
        `CHK({periph_clk_en, periph_io_block}, 16'hff00);
        wr(8'h0c, 32'h0f, 2'b00);
        wr(8'h10, 32'hf0, 2'b00);
        `CHK({in_buf_en_0, in_buf_en_1}, 16'hf00f);
        wr(8'h14, 32'h0, 2'b00);
        `CHK({adc_enable, adc_extended, vref_enable}, 3'h0);
        wr(8'h14, 32'h07, 2'b00);
        `CHK({adc_extended, vref_enable}, 2'h3);
        brownout_level_fuse <= 3'h4;
        wr(8'h14, 32'h0, 2'b00);
        `CHK({bod_enable, vref_enable}, 2'h3);
        {onchip_debug_fuse, test_port_fuse} <= 2'b11;
        repeat (3) @(posedge clock);
        `CHK(debug_enable, 1'b1);
        wr(8'h04, 32'h80, 2'b00);
        `CHK(debug_enable, 1'b0);
        wr(8'h00, 32'h5, 2'b00);
        sleep_now();
        `CHK({cpu_clk_on, main_osc_on}, 2'h1);
        fork
            core.wake(20);
            wait_run(c);
        join
        wr(8'h00, 32'h0, 2'b00);
        // frozen block keeps its last outputs
        clk_en <= 1'b0;
        brownout_level_fuse <= 3'h7;
        repeat (3) @(posedge clock);
        `CHK(bod_enable, 1'b1);
        clk_en <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK(bod_enable, 1'b0);
        end_sim();
    end
endmodule : tb_sleep_power_manager
bind sleep_power_manager spm_checker #(.NPIN(NPIN)) chk (.*);
